//--- core/owd_pkg.sv
// owd_pkg: constants shared by the watchdog modules
package owd_pkg;
  // ***********************************************************
  // register map and field layout
  // ***********************************************************
  localparam logic [7:0] OWD_CTRL_ADDR = 8'h00_e1;
  localparam logic [7:0] OWD_CTRL_RESET = 8'h00_00;
  localparam int OWD_FLAG_BIT = 7;
  localparam int OWD_ENABLE_BIT = 5;
  localparam int OWD_CLEAR_BIT = 4;
  localparam int OWD_IDLE_BIT = 3;
  localparam int OWD_PS_LSB = 0;
  localparam int OWD_PS_W = 3;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int OWD_CNT_W = 15;
  localparam logic [14:0] OWD_CNT_MAX = 15'h7fff;
  localparam int OWD_BASE_DIV = 12;
  localparam logic [3:0] OWD_BASE_LAST = 4'(OWD_BASE_DIV - 1);
  localparam int OWD_PRE_W = 8;
endpackage : owd_pkg

//--- core/owd_tick_if.sv
// owd_tick_if: tick and restart signals between the counter core and prescaler
`timescale 1ns/1ps
interface owd_tick_if;
  logic run;
  logic restart;
  logic [2:0] ps_code;
  logic tick;
  modport core
  (
    output run,
    output restart,
    output ps_code,
    input tick
  );
  modport pre
  (
    input run,
    input restart,
    input ps_code,
    output tick
  );
endinterface : owd_tick_if

//--- core/owd_prescaler.sv
// owd_prescaler: divide-by-12 base and selectable power-of-two prescale
`timescale 1ns/1ps
module owd_prescaler
  import owd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  owd_tick_if.pre tif
);
  // ***********************************************************
  // divider stages
  // ***********************************************************
  logic [3:0] base_reg;
  logic [3:0] base_next;
  logic [OWD_PRE_W-1:0] pre_reg;
  logic [OWD_PRE_W-1:0] pre_next;
  logic [OWD_PRE_W-1:0] pre_last;
  logic tick_reg;
  logic tick_next;

  // the shift amount is widened so that code 7 does not wrap to a divide by one
  assign pre_last = OWD_PRE_W'((9'h001 << ({1'b0, tif.ps_code} + 4'h1)) - 9'h001); // [RULE_06]
  assign tif.tick = tick_reg;

  always_comb
  begin
    base_next = base_reg;
    pre_next = pre_reg;
    tick_next = 1'b0;
    if (tif.restart)
    begin
      base_next = 4'h0; // [RULE_18]
      pre_next = '0;
    end
    else if (tif.run)
    begin
      if (base_reg == OWD_BASE_LAST) // [RULE_09]
      begin
        base_next = 4'h0;
        if (pre_reg >= pre_last) // [RULE_10]
        begin
          pre_next = '0;
          tick_next = 1'b1;
        end
        else
        begin
          pre_next = pre_reg + 1'b1;
        end
      end
      else
      begin
        base_next = base_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      base_reg <= 4'h0;
      pre_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      base_reg <= base_next;
      pre_reg <= pre_next;
      tick_reg <= tick_next;
    end
  end
endmodule : owd_prescaler

//--- core/owd_top.sv
// owd_top: one-time-enabled watchdog with control register and overflow reset
// Summary of operation
// RULE_01: overflow sets sticky flag bit 7; a software write or a power-on reset clears it.
// RULE_02: enable bit 5 starts watchdog; zero writes ignored; only power-on clears.
// RULE_03: writing one to clear bit 4 resets the 15-bit counter to zero.
// RULE_04: clear bit is a pulse; each later write of one clears again.
// RULE_05: in idle, count only when idle-run bit 3 is one.
// RULE_06: prescale code n divides by two to the power n plus one.
// RULE_07: after power-on the watchdog is disabled unless option enable presets it.
// RULE_08: counter reaching 7FFF overflows and resets the whole device.
// RULE_09: the base stage advances once every 12 system clocks while enabled.
// RULE_10: period is 2^15 times prescale times 12 clocks.
// RULE_11: control register survives all resets except power-on, which gives 0x00.
// RULE_12: software must clear the counter within each overflow period.
// RULE_13: in power-down the counter holds and needs no service.
// RULE_14: software should clear before power-down and after interrupt wake-up.
// RULE_15: option enable at power-up sets enable and loads idle and prescale options.
// RULE_16: software treats the register as write-only and keeps a shadow.
// RULE_17: with idle-run set, software uses a timer wake-up to service.
// RULE_18: a clear also restarts the divide-by-12 and prescale stages.
`timescale 1ns/1ps
module owd_top
  import owd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic option_enable,
  input wire logic option_idle_run,
  input wire logic [2:0] option_prescale,
  output logic watchdog_reset,
  output logic [14:0] count_value
);
  // ***********************************************************
  // control register state
  // ***********************************************************
  logic overflow_reset_flag_reg;
  logic overflow_reset_flag_next;
  logic watchdog_enable_reg;
  logic watchdog_enable_next;
  logic idle_run_reg;
  logic idle_run_next;
  logic [2:0] prescale_select_reg;
  logic [2:0] prescale_select_next;
  logic por_load_reg;
  logic por_load_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic wr_ctrl;
  logic counter_clear;
  logic overflow;
  logic rd_ctrl;
  logic [7:0] ctrl_view;

  // ***********************************************************
  // register decode
  // ***********************************************************
  assign wr_ctrl = reg_wr && (reg_addr == OWD_CTRL_ADDR);
  assign rd_ctrl = reg_rd && (reg_addr == OWD_CTRL_ADDR);
  assign counter_clear = wr_ctrl && reg_wdata[OWD_CLEAR_BIT]; // [RULE_03] [RULE_04]

  // por_n is the power-on reset: it alone returns the control register to zero.
  // resetn (hardware, software, watchdog resets) leaves the register alone.
  always_comb
  begin
    overflow_reset_flag_next = overflow_reset_flag_reg;
    watchdog_enable_next = watchdog_enable_reg;
    idle_run_next = idle_run_reg;
    prescale_select_next = prescale_select_reg;
    por_load_next = 1'b0;
    if (por_load_reg)
    begin
      if (option_enable) // [RULE_07] [RULE_15]
      begin
        watchdog_enable_next = 1'b1;
        idle_run_next = option_idle_run;
        prescale_select_next = option_prescale;
      end
    end
    // a write in the option-load cycle is dropped so the options land intact
    else if (wr_ctrl)
    begin
      overflow_reset_flag_next = reg_wdata[OWD_FLAG_BIT];
      watchdog_enable_next = watchdog_enable_reg | reg_wdata[OWD_ENABLE_BIT]; // [RULE_02]
      idle_run_next = reg_wdata[OWD_IDLE_BIT];
      prescale_select_next = reg_wdata[OWD_PS_LSB +: OWD_PS_W];
    end
    // set wins over a software clear in the same cycle
    if (overflow)
    begin
      overflow_reset_flag_next = 1'b1; // [RULE_01]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!por_n)
    begin
      overflow_reset_flag_reg <= OWD_CTRL_RESET[OWD_FLAG_BIT]; // [RULE_11]
      watchdog_enable_reg <= OWD_CTRL_RESET[OWD_ENABLE_BIT];
      idle_run_reg <= OWD_CTRL_RESET[OWD_IDLE_BIT];
      prescale_select_reg <= OWD_CTRL_RESET[OWD_PS_LSB +: OWD_PS_W];
      por_load_reg <= 1'b1;
    end
    else
    begin
      overflow_reset_flag_reg <= overflow_reset_flag_next;
      watchdog_enable_reg <= watchdog_enable_next;
      idle_run_reg <= idle_run_next;
      prescale_select_reg <= prescale_select_next;
      por_load_reg <= por_load_next;
    end
  end

  // ***********************************************************
  // counter and overflow
  // ***********************************************************
  owd_tick_if tif ();
  logic [14:0] cnt_reg;
  logic [14:0] cnt_next;
  logic wdrst_reg;
  logic wdrst_next;
  logic cnt_step;

  // oscillator is off in power-down, so nothing advances there
  assign tif.run = watchdog_enable_reg && !power_down && (!idle_mode || idle_run_reg); // [RULE_05] [RULE_13]
  // held clear while disabled so that enabling starts a full period
  assign tif.restart = counter_clear || overflow || !watchdog_enable_reg; // [RULE_18]
  assign tif.ps_code = prescale_select_reg;
  // a full count waits out power-down and overflows after the wake-up
  assign overflow = watchdog_enable_reg && !power_down && (cnt_reg == OWD_CNT_MAX); // [RULE_08] [RULE_13]
  assign cnt_step = tif.tick && tif.run;

  // ***********************************************************
  // prescaler
  // ***********************************************************
  owd_prescaler u_pre
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .tif(tif)
  );

  // ***********************************************************
  // count and reset pulse
  // ***********************************************************
  // clear and overflow win over a tick landing in the same cycle
  always_comb
  begin
    cnt_next = cnt_reg;
    wdrst_next = overflow;
    if (counter_clear || overflow)
    begin
      cnt_next = 15'h0000; // [RULE_03]
    end
    else if (cnt_step)
    begin
      cnt_next = cnt_reg + 15'h0001; // [RULE_10]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cnt_reg <= 15'h0000;
      wdrst_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      wdrst_reg <= wdrst_next; // [RULE_08]
    end
  end

  // ***********************************************************
  // read port
  // ***********************************************************
  // clear bit reads zero since it is only a strobe; bit 6 reserved
  always_comb
  begin
    ctrl_view = OWD_CTRL_RESET;
    ctrl_view[OWD_FLAG_BIT] = overflow_reset_flag_reg;
    ctrl_view[OWD_ENABLE_BIT] = watchdog_enable_reg;
    ctrl_view[OWD_IDLE_BIT] = idle_run_reg;
    ctrl_view[OWD_PS_LSB +: OWD_PS_W] = prescale_select_reg;
  end

  always_comb
  begin
    rdata_next = 8'h00;
    if (rd_ctrl)
    begin
      rdata_next = ctrl_view;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // watchdog_reset is meant to drive the chip reset that arrives here as resetn
  assign reg_rdata = rdata_reg;
  assign watchdog_reset = wdrst_reg;
  assign count_value = cnt_reg;
endmodule : owd_top

//--- verif/owd_top_sva.sv
// owd_top_sva: port assertions for the watchdog top
`timescale 1ns/1ps
module owd_top_sva
  import owd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic power_down,
  input wire logic watchdog_reset,
  input wire logic [14:0] count_value
);
  // ***********************************************************
  // counter, reset pulse and read port
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire clr_w = reg_wr && reg_addr == OWD_CTRL_ADDR && reg_wdata[OWD_CLEAR_BIT];
  chk_clear_zero: assert property (clr_w |=> count_value == 15'h0000)
    else $error("count not cleared");
  // the shortest period is 24 cycles, so 8 idle cycles flag a stage left running
  chk_clear_restart: assert property (clr_w |=> (count_value == 15'h0000) [*8])
    else $error("count moved too soon after clear");
  chk_pd_hold: assert property (power_down && !clr_w |=> $stable(count_value))
    else $error("count moved in power down");
  chk_step_one: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 15'h0001 || count_value == 15'h0000)
    else $error("count jumped");
  chk_tick_gap: assert property ($changed(count_value) && count_value != 15'h0000 |=>
    ($stable(count_value) || count_value == 15'h0000) [*8])
    else $error("ticks too close");
  chk_rst_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("reset pulse too long");
  chk_rst_cause: assert property ($rose(watchdog_reset) |-> $past(count_value) == OWD_CNT_MAX)
    else $error("reset without full count");
  chk_rst_wrap: assert property (watchdog_reset |-> count_value == 15'h0000)
    else $error("count not wrapped on reset");
  chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  chk_rd_clrbit: assert property (reg_rd |=> !reg_rdata[OWD_CLEAR_BIT])
    else $error("clear bit read back high");
  cover property (clr_w);
  cover property (power_down && count_value != 15'h0000);
  cover property ($changed(count_value));
endmodule : owd_top_sva
bind owd_top owd_top_sva u_sva
(
  .core_clk(core_clk),
  .resetn(resetn),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .power_down(power_down),
  .watchdog_reset(watchdog_reset),
  .count_value(count_value)
);

//--- verif/owd_top_tb_top.sv
// owd_top_tb_top: scenario bench for the watchdog top
`timescale 1ns/1ps
module owd_top_tb_top import owd_pkg::*;;
  logic core_clk = 1'b0, resetn = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic idle_mode = 1'b0, power_down = 1'b0, option_enable = 1'b0, option_idle_run = 1'b0;
  logic [7:0] reg_addr = OWD_CTRL_ADDR, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] option_prescale = 3'h0;
  logic watchdog_reset;
  logic [14:0] count_value;
  int fails = 0, cmp_count = 0, cycles = 0;
  owd_top dut
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .por_n(por_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .idle_mode(idle_mode),
    .power_down(power_down),
    .option_enable(option_enable),
    .option_idle_run(option_idle_run),
    .option_prescale(option_prescale),
    .watchdog_reset(watchdog_reset),
    .count_value(count_value)
  );
  always #10 core_clk = ~core_clk;
  // ***********************************************************
  // helpers
  // ***********************************************************
  // full overflow needs 786408 cycles at least, so it is left to the checker
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      conclude();
    end
  end
  task conclude();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task chk(string nm, logic [14:0] seen, logic [14:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task rdchk(string nm, logic [7:0] exp);
    @(negedge core_clk);
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(nm, 15'(reg_rdata), 15'(exp));
  endtask : rdchk
  task wait_n(int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n
  // ***********************************************************
  // scenarios
  // ***********************************************************
  task t_count();
    rdchk("ctrl after power on", 8'h00);
    wr(8'h30);
    wait_n(132);
    chk("count ps0", count_value, 15'h0005);
    wr(8'h00);
    rdchk("enable kept", 8'h20);
    wr(8'hA0);
    rdchk("flag written", 8'hA0);
    wr(8'h20);
    rdchk("flag cleared", 8'h20);
    $display("t_count done");
  endtask : t_count
  task t_clear();
    wr(8'h30);
    chk("clear", count_value, 15'h0000);
    wait_n(30);
    wr(8'h30);
    chk("clear again", count_value, 15'h0000);
    wait_n(22);
    chk("restart", count_value, 15'h0000);
    $display("t_clear done");
  endtask : t_clear
  task t_ps();
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h30 | 8'(c));
      wait_n(30 * (2 << c));
      chk("prescale", count_value, 15'h0002);
    end
    $display("t_ps done");
  endtask : t_ps
  task t_idle();
    idle_mode = 1'b1;
    wr(8'h30);
    wait_n(100);
    chk("idle hold", count_value, 15'h0000);
    wr(8'h38);
    wait_n(60);
    chk("idle run", count_value, 15'h0002);
    idle_mode = 1'b0;
    wr(8'h30);
    wait_n(36);
    power_down = 1'b1;
    wait_n(100);
    chk("power down", count_value, 15'h0001);
    power_down = 1'b0;
    wr(8'h30);
    chk("wake clear", count_value, 15'h0000);
    chk("no reset pulse", 15'(watchdog_reset), 15'h0000);
    $display("t_idle done");
  endtask : t_idle
  task t_resets();
    wr(8'h2D);
    resetn = 1'b0;
    wait_n(8);
    resetn = 1'b1;
    chk("count reset", count_value, 15'h0000);
    rdchk("ctrl kept", 8'h2D);
    por_n = 1'b0;
    resetn = 1'b0;
    option_enable = 1'b1;
    option_idle_run = 1'b1;
    option_prescale = 3'h3;
    wait_n(8);
    por_n = 1'b1;
    resetn = 1'b1;
    wait_n(2);
    rdchk("option load", 8'h2B);
    $display("t_resets done");
  endtask : t_resets
  initial
  begin
    wait_n(8);
    resetn = 1'b1;
    por_n = 1'b1;
    wait_n(2);
    t_count();
    t_clear();
    t_ps();
    t_idle();
    t_resets();
    conclude();
  end
endmodule : owd_top_tb_top
